// File: rtl/nvmcs_top.sv
// How it works
// [RULE1] Busy register bit 0 reads 1 while a save or load transfer runs.
// [RULE2] With the status select input high, the status pin shows the busy flag.
// [RULE3] Error register bit 0 is 1 when loaded data fails its check, else 0.
// [RULE4] With select pin low, control bit 1 soft-resets and reloads; bit self-clears.
// [RULE5] Control bit 0 resets to 0, blocking writes; 1 allows them.
// [RULE6] Host waits at least 10 us between successive save or load transfers.
// [RULE7] Save bit 0 starts buffer-to-array copy and clears when it finishes.
// [RULE8] Command with bit 7 clear: low bits are count minus one, then address high, low.
// [RULE9] Command with bit 7 set is an opcode: update, or end which stops transfer.
// [RULE10] Update bit, or update opcode during a load, pulses the buffer-to-active copy next edge.
// [RULE11] A save request while writes are blocked is ignored.
`timescale 1ns/1ps
`include "nvmcs_params.svh"

module nvmcs_top
	import nvmcs_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	input wire logic ce,
	// Serial control port register access
	input wire logic [11:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata_q,
	// Buffer register bank
	output logic buf_rd_q,
	output logic buf_wr_q,
	output logic [15:0] buf_addr_q,
	output logic [7:0] buf_wdata_q,
	input wire logic [7:0] buf_rdata,
	// Pins and device controls
	input wire logic nvm_sel_n,
	input wire logic status_sel,
	input wire logic status_other,
	output logic status_pin_q,
	output logic io_update_q,
	output logic soft_rst_q
);

	nvmcs_state_t q;
	nvmcs_state_t d;
	logic [7:0] nvm_rdata;
	logic [7:0] rx;
	logic busy;

	function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
		return a == off;
	endfunction : hit

	nvmcs_nvm_mem #(
		.DW(8),
		.AW(`NVMCS_NVM_AW),
		.DEPTH(`NVMCS_NVM_DEPTH)
	) u_mem (
		.clock(clock),
		.ce(ce),
		.wr(q.nvm_wr),
		.rd(q.nvm_rd),
		.addr(q.nvm_addr),
		.wdata(q.nvm_wdata),
		.rdata_q(nvm_rdata)
	);

	assign rx = q.save_op ? buf_rdata : nvm_rdata;
	assign busy = q.st != S_IDLE;

	always_comb begin
		logic stop;
		stop = 1'b0;
		d = q;
		d.buf_rd = 1'b0;
		d.buf_wr = 1'b0;
		d.nvm_rd = 1'b0;
		d.nvm_wr = 1'b0;
		d.io_update = 1'b0;
		d.soft_rst = 1'b0;
		d.sel_sync = {q.sel_sync[0], nvm_sel_n};
		d.status_pin = status_sel ? busy : status_other; // [RULE2]
		unique case (q.st)
			S_IDLE: begin
			end
			S_SOFT: begin
				d.st = S_RD;
				d.save_op = 1'b0;
				d.nvm_ptr = '0;
				d.csum = 8'h00;
				d.phase = PH_CMD;
				d.err = 1'b0;
			end
			S_RD: begin
				if (q.save_op) begin
					d.buf_rd = 1'b1;
					d.buf_addr = (q.phase == PH_DAT) ? q.addr : (`NVMCS_SEG_BASE | {8'h00, q.seg_ptr});
				end else begin
					d.nvm_rd = 1'b1;
					d.nvm_addr = q.nvm_ptr;
				end
				d.st = S_WT;
			end
			S_WT: begin
				d.st = S_USE;
			end
			S_USE: begin
				if (q.phase != PH_CS) begin
					d.csum = q.csum ^ rx;
				end
				if (q.save_op) begin
					d.nvm_wr = 1'b1;
					d.nvm_addr = q.nvm_ptr;
					d.nvm_wdata = rx;
				end
				d.nvm_ptr = q.nvm_ptr + 1'b1;
				d.st = S_RD;
				unique case (q.phase)
					PH_CMD: begin
						d.seg_ptr = q.seg_ptr + 8'h01;
						if (!rx[`NVMCS_B_OPC]) begin // [RULE8]
							d.cnt = rx[6:0];
							d.phase = PH_AH;
						end else if (rx == `NVMCS_OP_UPDATE) begin // [RULE9]
							d.io_update = !q.save_op; // [RULE10]
						end else if (rx == `NVMCS_OP_END) begin // [RULE9]
							if (q.save_op) begin
								d.st = S_FIN;
							end else begin
								d.phase = PH_CS;
							end
						end else begin
							stop = 1'b1;
						end
					end
					PH_AH: begin
						d.seg_ptr = q.seg_ptr + 8'h01;
						d.addr[15:8] = rx; // [RULE8]
						d.phase = PH_AL;
					end
					PH_AL: begin
						d.seg_ptr = q.seg_ptr + 8'h01;
						d.addr[7:0] = rx; // [RULE8]
						d.phase = PH_DAT;
					end
					PH_DAT: begin
						if (!q.save_op) begin
							d.buf_wr = 1'b1;
							d.buf_addr = q.addr;
							d.buf_wdata = rx;
						end
						d.addr = q.addr + 16'h0001;
						if (q.cnt == 7'h00) begin // [RULE8]
							d.phase = PH_CMD;
						end else begin
							d.cnt = q.cnt - 7'h01;
						end
					end
					PH_CS: begin
						d.err = rx != q.csum; // [RULE3]
						d.st = S_IDLE;
					end
					default: begin
						stop = 1'b1;
					end
				endcase
				// Running off the array or the segment is a broken image
				if (d.st != S_IDLE && (q.nvm_ptr == `NVMCS_NVM_LAST ||
						(q.save_op && q.phase != PH_DAT && q.seg_ptr == `NVMCS_SEG_LAST && d.st == S_RD))) begin
					stop = 1'b1;
				end
				if (stop) begin
					d.st = S_IDLE;
					d.err = !q.save_op; // [RULE3]
					d.save_q = 1'b0;
				end
			end
			S_FIN: begin
				d.nvm_wr = 1'b1;
				d.nvm_addr = q.nvm_ptr;
				d.nvm_wdata = q.csum;
				d.save_q = 1'b0; // [RULE7]
				d.st = S_IDLE;
			end
			default: begin
				d.st = S_IDLE;
			end
		endcase
		if (reg_wr) begin
			if (hit(reg_addr, `NVMCS_A_CTRL)) begin
				d.wen = reg_wdata[`NVMCS_B_WEN]; // [RULE5]
				if (reg_wdata[`NVMCS_B_SOFT] && !q.sel_sync[1] && !busy) begin // [RULE4]
					d.soft_rst = 1'b1;
					d.wen = `NVMCS_WEN_RST; // [RULE5]
					d.st = S_SOFT;
				end
			end
			if (hit(reg_addr, `NVMCS_A_SAVE) && reg_wdata[`NVMCS_B_SAVE] && q.wen && !busy) begin // [RULE7] [RULE11]
				d.save_q = 1'b1;
				d.save_op = 1'b1;
				d.st = S_RD;
				d.seg_ptr = 8'h00;
				d.nvm_ptr = '0;
				d.csum = 8'h00;
				d.phase = PH_CMD;
			end
			if (hit(reg_addr, `NVMCS_A_UPD) && reg_wdata[`NVMCS_B_UPD]) begin
				d.io_update = 1'b1; // [RULE10]
			end
		end
		if (reg_rd) begin
			d.rdata = 8'h00;
			if (hit(reg_addr, `NVMCS_A_BUSY)) begin
				d.rdata[0] = busy; // [RULE1]
			end
			if (hit(reg_addr, `NVMCS_A_ERR)) begin
				d.rdata[0] = q.err; // [RULE3]
			end
			if (hit(reg_addr, `NVMCS_A_CTRL)) begin
				d.rdata[`NVMCS_B_WEN] = q.wen; // [RULE4] [RULE5]
			end
			if (hit(reg_addr, `NVMCS_A_SAVE)) begin
				d.rdata[`NVMCS_B_SAVE] = q.save_q; // [RULE7]
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			q <= NVMCS_RST;
		end else if (ce) begin
			q <= d;
		end
	end

	assign reg_rdata_q = q.rdata;
	assign buf_rd_q = q.buf_rd;
	assign buf_wr_q = q.buf_wr;
	assign buf_addr_q = q.buf_addr;
	assign buf_wdata_q = q.buf_wdata;
	assign status_pin_q = q.status_pin;
	assign io_update_q = q.io_update;
	assign soft_rst_q = q.soft_rst;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst || !ce);

	a_busy_read: assert property (reg_rd && hit(reg_addr, `NVMCS_A_BUSY) |=> reg_rdata_q == {7'h00, $past(busy)}) // [RULE1]
		else $error("busy register does not match transfer state");
	a_status_pin_mux: assert property (!rst |=> status_pin_q == $past(status_sel ? busy : status_other)) // [RULE2]
		else $error("status pin does not follow select");
	a_err_on_check: assert property (q.st == S_USE && !q.save_op && q.phase == PH_CS |=> q.err == $past(rx != q.csum)) // [RULE3]
		else $error("error flag does not reflect check");
	a_soft_reload: assert property (reg_wr && hit(reg_addr, `NVMCS_A_CTRL) && reg_wdata[1] && !q.sel_sync[1] && !busy
		|=> soft_rst_q && !q.wen ##1 (q.st == S_RD && !q.save_op && !soft_rst_q)) // [RULE4]
		else $error("soft reset did not pulse and start reload");
	a_soft_selfclear: assert property (reg_rd && hit(reg_addr, `NVMCS_A_CTRL) |=> reg_rdata_q[7:1] == 7'h00) // [RULE4]
		else $error("soft reset bit reads back set");
	a_protect_save: assert property (reg_wr && hit(reg_addr, `NVMCS_A_SAVE) && !q.wen && !busy |=> !q.save_q && !busy) // [RULE11]
		else $error("save started while write protected");
	a_save_start: assert property (reg_wr && hit(reg_addr, `NVMCS_A_SAVE) && reg_wdata[0] && q.wen && !busy
		|=> q.save_q && q.st == S_RD) // [RULE7]
		else $error("save request not taken");
	a_save_clear: assert property ($fell(q.save_q) |-> q.st == S_IDLE) // [RULE7]
		else $error("save bit cleared before transfer end");
	a_cmd_decode: assert property (q.st == S_USE && q.phase == PH_CMD && !rx[7] && q.nvm_ptr != `NVMCS_NVM_LAST
		&& !(q.save_op && q.seg_ptr == `NVMCS_SEG_LAST)
		|=> q.phase == PH_AH && q.cnt == $past(rx[6:0]) ##1 q.st == S_WT) // [RULE8]
		else $error("data command decoded wrongly");
	a_end_opcode: assert property (q.st == S_USE && q.phase == PH_CMD && rx == `NVMCS_OP_END && q.save_op
		&& q.nvm_ptr != `NVMCS_NVM_LAST |=> q.st == S_FIN ##1 q.st == S_IDLE) // [RULE9]
		else $error("end opcode did not terminate save");
	a_update_bit: assert property (reg_wr && hit(reg_addr, `NVMCS_A_UPD) && reg_wdata[0] |=> io_update_q ##1 !io_update_q) // [RULE10]
		else $error("update bit did not pulse once");
	a_update_op: assert property (q.st == S_USE && q.phase == PH_CMD && rx == `NVMCS_OP_UPDATE && !q.save_op |=> io_update_q) // [RULE10]
		else $error("update opcode did not pulse");

	c_save_done: cover property ($fell(q.save_q));
	c_load_error: cover property ($rose(q.err));
	c_soft_reset: cover property (soft_rst_q ##[1:200] !busy);

endmodule : nvmcs_top

// File: include/nvmcs_params.svh
`ifndef NVMCS_PARAMS_SVH
`define NVMCS_PARAMS_SVH

// Register addresses on the serial control port
`define NVMCS_A_BUSY 12'hB00
`define NVMCS_A_ERR 12'hB01
`define NVMCS_A_CTRL 12'hB02
`define NVMCS_A_SAVE 12'hB03
`define NVMCS_A_UPD 12'h232

// Bit positions
`define NVMCS_B_WEN 0
`define NVMCS_B_SOFT 1
`define NVMCS_B_SAVE 0
`define NVMCS_B_UPD 0
`define NVMCS_B_OPC 7

// Reset value of the write-enable bit
`define NVMCS_WEN_RST 1'b0

// Select synchroniser starts deselected so no soft reload sneaks in after reset
`define NVMCS_SEL_RST 2'b11

// Segment command encodings
`define NVMCS_OP_UPDATE 8'h80
`define NVMCS_OP_END 8'hFF

// Buffer segment window
`define NVMCS_SEG_BASE 16'h0A00
`define NVMCS_SEG_LAST 8'hFF

// Nonvolatile array geometry
`define NVMCS_NVM_AW 9
`define NVMCS_NVM_DEPTH 512
`define NVMCS_NVM_LAST 9'h1FF

`endif

// File: include/nvmcs_pkg.sv
`include "nvmcs_params.svh"

package nvmcs_pkg;

	typedef enum logic [5:0] {
		S_IDLE = 6'h01,
		S_SOFT = 6'h02,
		S_RD = 6'h04,
		S_WT = 6'h08,
		S_USE = 6'h10,
		S_FIN = 6'h20
	} nvmcs_st_t;

	typedef enum logic [2:0] {
		PH_CMD = 3'h0,
		PH_AH = 3'h1,
		PH_AL = 3'h2,
		PH_DAT = 3'h3,
		PH_CS = 3'h4
	} nvmcs_ph_t;

	typedef struct packed {
		nvmcs_st_t st;
		nvmcs_ph_t phase;
		logic save_op;
		logic wen;
		logic save_q;
		logic err;
		logic [6:0] cnt;
		logic [15:0] addr;
		logic [7:0] seg_ptr;
		logic [`NVMCS_NVM_AW-1:0] nvm_ptr;
		logic [7:0] csum;
		logic [7:0] rdata;
		logic buf_rd;
		logic buf_wr;
		logic [15:0] buf_addr;
		logic [7:0] buf_wdata;
		logic nvm_rd;
		logic nvm_wr;
		logic [`NVMCS_NVM_AW-1:0] nvm_addr;
		logic [7:0] nvm_wdata;
		logic io_update;
		logic soft_rst;
		logic status_pin;
		logic [1:0] sel_sync;
	} nvmcs_state_t;

	parameter nvmcs_state_t NVMCS_RST = '{st: S_IDLE, phase: PH_CMD, wen: `NVMCS_WEN_RST,
		sel_sync: `NVMCS_SEL_RST, default: '0};

endpackage : nvmcs_pkg

// File: rtl/nvmcs_nvm_mem.sv
`timescale 1ns/1ps
`include "nvmcs_params.svh"

module nvmcs_nvm_mem #(
	parameter int DW = 8,
	parameter int AW = `NVMCS_NVM_AW,
	parameter int DEPTH = `NVMCS_NVM_DEPTH
) (
	// Clock
	input wire logic clock,
	input wire logic ce,
	// Access
	input wire logic wr,
	input wire logic rd,
	input wire logic [AW-1:0] addr,
	input wire logic [DW-1:0] wdata,
	output logic [DW-1:0] rdata_q
);

	logic [DW-1:0] mem [DEPTH];

	always_ff @(posedge clock) begin
		if (ce) begin
			if (wr) begin
				mem[addr] <= wdata;
			end
			if (rd) begin
				rdata_q <= mem[addr];
			end
		end
	end

endmodule : nvmcs_nvm_mem

// File: verification/nvmcs_buf_model.sv
`timescale 1ns/1ps

module nvmcs_buf_model (
	// Clock
	input wire logic clock,
	// Buffer bank access
	input wire logic rd,
	input wire logic wr,
	input wire logic [15:0] addr,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata
);
	logic [7:0] mem [0:65535];
	logic [7:0] last;
	initial begin
		foreach (mem[i]) mem[i] = 8'h00;
		rdata = 8'h00;
		last = 8'h00;
	end
	always @(posedge clock) begin
		if (wr) mem[addr] <= wdata;
		// Data valid one cycle only, then junk
		if (rd) begin
			rdata <= mem[addr];
			last <= mem[addr];
		end else begin
			rdata <= ~last;
		end
	end
endmodule : nvmcs_buf_model

// File: verification/nvm_config_save_control_tb.sv
`timescale 1ns/1ps
`include "nvmcs_params.svh"

module nvm_config_save_control_tb;
	import nvmcs_pkg::*;
	logic clock, rst, ce, reg_wr, reg_rd, nvm_sel_n, status_sel, status_other;
	logic buf_rd_q, buf_wr_q, status_pin_q, io_update_q, soft_rst_q;
	logic [11:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata_q, buf_wdata_q, buf_rdata, v;
	logic [15:0] buf_addr_q;
	int error_cnt, checked, upd_n, soft_n, rd_n, n;
	nvmcs_top u_dut (.clock(clock), .rst(rst), .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .buf_rd_q(buf_rd_q), .buf_wr_q(buf_wr_q),
		.buf_addr_q(buf_addr_q), .buf_wdata_q(buf_wdata_q), .buf_rdata(buf_rdata), .nvm_sel_n(nvm_sel_n),
		.status_sel(status_sel), .status_other(status_other), .status_pin_q(status_pin_q),
		.io_update_q(io_update_q), .soft_rst_q(soft_rst_q));
	nvmcs_buf_model u_buf (.clock(clock), .rd(buf_rd_q), .wr(buf_wr_q), .addr(buf_addr_q), .wdata(buf_wdata_q),
		.rdata(buf_rdata));
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	always @(posedge clock) begin
		if (io_update_q === 1'b1) upd_n++;
		if (soft_rst_q === 1'b1) soft_n++;
		if (buf_rd_q === 1'b1) rd_n++;
	end
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e) begin
			$display("[ERR] %s expected %h seen %h", nm, e, g);
			error_cnt++;
		end
	endtask : chk
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [11:0] a);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 v = reg_rdata_q;
	endtask : rd
	task automatic wait_idle();
		for (int i = 0; i < 3000; i++) begin
			rd(`NVMCS_A_BUSY);
			if (v === 8'h00) break;
		end
		chk("busy end", 8'h00, v);
		// Host gap between transfers
		repeat (1250) @(posedge clock);
	endtask : wait_idle
	task automatic t_reset();
		rd(`NVMCS_A_BUSY); chk("busy", 8'h00, v);
		rd(`NVMCS_A_ERR); chk("err", 8'h00, v);
		rd(`NVMCS_A_CTRL); chk("ctrl", 8'h00, v);
		rd(`NVMCS_A_SAVE); chk("save", 8'h00, v);
		rd(12'h123); chk("unmapped", 8'h00, v);
	endtask : t_reset
	task automatic t_protect();
		wr(`NVMCS_A_SAVE, 8'h01);
		repeat (4) @(posedge clock);
		chk("reads", 8'h00, 8'(rd_n));
		rd(`NVMCS_A_SAVE); chk("save", 8'h00, v);
	endtask : t_protect
	task automatic t_update();
		n = upd_n;
		wr(`NVMCS_A_UPD, 8'h01);
		repeat (3) @(posedge clock);
		chk("upd", 8'h01, 8'(upd_n - n));
	endtask : t_update
	task automatic t_save();
		u_buf.mem[16'h0A00] = 8'h01;
		u_buf.mem[16'h0A01] = 8'h00;
		u_buf.mem[16'h0A02] = 8'h10;
		u_buf.mem[16'h0A03] = 8'h80;
		u_buf.mem[16'h0A04] = 8'hFF;
		u_buf.mem[16'h0010] = 8'h5A;
		u_buf.mem[16'h0011] = 8'hC3;
		n = upd_n;
		@(posedge clock) status_sel <= 1'b1;
		wr(`NVMCS_A_CTRL, 8'h01);
		rd(`NVMCS_A_CTRL);
		chk("ctrl wen", 8'h01, v);
		wr(`NVMCS_A_SAVE, 8'h01);
		rd(`NVMCS_A_SAVE); chk("save run", 8'h01, v);
		rd(`NVMCS_A_BUSY); chk("busy run", 8'h01, v);
		chk("pin busy", 8'h01, 8'(status_pin_q));
		wait_idle();
		rd(`NVMCS_A_SAVE); chk("save end", 8'h00, v);
		chk("pin idle", 8'h00, 8'(status_pin_q));
		@(posedge clock) status_sel <= 1'b0;
		status_other <= 1'b1;
		repeat (3) @(posedge clock);
		chk("pin other", 8'h01, 8'(status_pin_q));
		chk("upd save", 8'h00, 8'(upd_n - n));
	endtask : t_save
	task automatic t_soft();
		u_buf.mem[16'h0010] = 8'h00;
		u_buf.mem[16'h0011] = 8'h00;
		n = upd_n;
		wr(`NVMCS_A_CTRL, 8'h02);
		repeat (3) @(posedge clock);
		chk("soft sel hi", 8'h00, 8'(soft_n));
		@(posedge clock) nvm_sel_n <= 1'b0;
		repeat (3) @(posedge clock);
		wr(`NVMCS_A_CTRL, 8'h02);
		wait_idle();
		chk("soft", 8'h01, 8'(soft_n));
		chk("data0", 8'h5A, u_buf.mem[16'h0010]);
		chk("data1", 8'hC3, u_buf.mem[16'h0011]);
		chk("upd op", 8'h01, 8'(upd_n - n));
		rd(`NVMCS_A_ERR); chk("err ok", 8'h00, v);
		rd(`NVMCS_A_CTRL); chk("ctrl", 8'h00, v);
	endtask : t_soft
	task automatic t_error();
		// No end marker fits: save aborts, load runs off the array
		for (int i = 0; i < 4; i++) begin
			u_buf.mem[16'h0A00 + 3 * i] = 8'h7F;
			u_buf.mem[16'h0A01 + 3 * i] = 8'h00;
			u_buf.mem[16'h0A02 + 3 * i] = 8'h00;
		end
		u_buf.mem[16'h0A0C] = 8'hFF;
		wr(`NVMCS_A_CTRL, 8'h01);
		wr(`NVMCS_A_SAVE, 8'h01);
		wait_idle();
		wr(`NVMCS_A_CTRL, 8'h02);
		wait_idle();
		rd(`NVMCS_A_ERR); chk("err bad", 8'h01, v);
	endtask : t_error
	task automatic t_freeze();
		// Strobes seen while the enable is low are lost
		n = upd_n;
		@(posedge clock) ce <= 1'b0;
		wr(`NVMCS_A_UPD, 8'h01);
		repeat (3) @(posedge clock);
		ce <= 1'b1;
		repeat (3) @(posedge clock);
		chk("upd frozen", 8'h00, 8'(upd_n - n));
		wr(`NVMCS_A_UPD, 8'h01);
		repeat (3) @(posedge clock);
		chk("upd thawed", 8'h01, 8'(upd_n - n));
	endtask : t_freeze
	task automatic t_midrst();
		// Reset in the middle of a save
		wr(`NVMCS_A_CTRL, 8'h01);
		wr(`NVMCS_A_SAVE, 8'h01);
		repeat (20) @(posedge clock);
		rd(`NVMCS_A_BUSY);
		chk("busy pre", 8'h01, v);
		@(posedge clock) rst <= 1'b1;
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		rd(`NVMCS_A_BUSY);
		chk("busy rst", 8'h00, v);
		rd(`NVMCS_A_SAVE);
		chk("save rst", 8'h00, v);
		rd(`NVMCS_A_CTRL);
		chk("ctrl rst", 8'h00, v);
		rd(`NVMCS_A_ERR);
		chk("err rst", 8'h00, v);
	endtask : t_midrst
	task automatic test_done();
		$display("errors %0d checks %0d", error_cnt, checked);
		if (error_cnt == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : test_done
	initial begin
		rst = 1'b1; ce = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 12'h000; reg_wdata = 8'h00;
		nvm_sel_n = 1'b1; status_sel = 1'b0; status_other = 1'b0;
		repeat (6) @(posedge clock);
		rst <= 1'b0;
		repeat (3) @(posedge clock);
		t_reset();
		t_protect();
		t_update();
		t_save();
		t_soft();
		t_error();
		t_freeze();
		t_midrst();
		test_done();
	end
	initial begin
		repeat (60000) @(posedge clock);
		error_cnt++;
		test_done();
	end
endmodule : nvm_config_save_control_tb
